/* File: tcd_dma.sv */
// ten-channel dma controller: register slave, request selection, arbiter and transfer engine
//
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module tcd_dma
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire tcd_pkg::tcd_evt_s evt,
   output logic bus_req,
   input wire logic bus_gnt,
   output tcd_pkg::tcd_mem_s mem,
   input wire logic [15:0] mem_rdata,
   input wire logic mem_ready,
   output logic [tcd_pkg::NCH-1:0] irq
);

   typedef struct packed {
      tcd_pkg::tcd_state_e st;
      logic [tcd_pkg::NCH-1:0][tcd_pkg::CTRL_W-1:0] ctrl;
      logic [tcd_pkg::NCH-1:0][15:0] src;
      logic [tcd_pkg::NCH-1:0][15:0] dst;
      logic [tcd_pkg::NCH-1:0][7:0] cnt;
      logic [tcd_pkg::NCH-1:0] pend;
      logic [tcd_pkg::NCH-1:0] status;
      logic [tcd_pkg::NCH-1:0] mask;
      logic [tcd_pkg::NCH-1:0] irq;
      logic [tcd_pkg::NCH-1:0] one_done;
      logic [tcd_pkg::NCH-1:0] all_done;
      logic [3:0] cur;
      logic [7:0] hold_byte;
      logic [15:0] hold;
      logic bus_req;
      tcd_pkg::tcd_mem_s mem;
      logic wr_ph;
      logic [11:0] waddr;
      logic [31:0] hrdata;
      logic hreadyout;
   } tcd_core_s;

   tcd_core_s s_q;
   tcd_core_s s_d;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic cause_of(input logic [3:0] ch, input logic [1:0] sel, input tcd_pkg::tcd_evt_s e,
      input logic [9:0] sw, input logic [9:0] one, input logic [9:0] all);
      logic r;
      r = 1'b0;
      case (ch)
         4'h0:
            case (sel) // see R3
               2'h0: r = sw[0] | one[2];
               2'h1: r = e.converter_0_done;
               2'h2: r = e.timer_ch8_underflow;
               default: r = e.in_evt_bus[2];
            endcase
         4'h1:
            case (sel) // see R4
               2'h0: r = sw[1];
               2'h1: r = e.out_evt_bus[0];
               2'h2: r = 1'b0;
               default: r = one[0];
            endcase
         4'h2:
            case (sel) // see R5
               2'h0: r = sw[2];
               2'h1: r = e.out_evt_bus[1];
               2'h2: r = e.timer_input_18;
               default: r = one[1];
            endcase
         4'h3:
            case (sel) // see R6
               2'h0: r = sw[3];
               2'h1: r = e.sio_tx_empty[0];
               2'h2: r = e.sio_rx_done[1];
               default: r = e.timer_input_0;
            endcase
         4'h4:
            case (sel) // see R7
               2'h0: r = sw[4];
               2'h1: r = one[3];
               2'h2: r = e.sio_rx_done[0];
               default: r = e.timer_input_19;
            endcase
         4'h5:
            case (sel) // see R8
               2'h0: r = sw[5] | one[7];
               2'h1: r = all[0];
               2'h2: r = e.sio_rx_done[2];
               default: r = e.timer_input_20;
            endcase
         4'h6:
            case (sel) // see R9
               2'h0: r = sw[6];
               2'h1: r = e.sio_tx_empty[1];
               2'h2: r = 1'b0;
               default: r = one[5];
            endcase
         4'h7:
            case (sel) // see R10
               2'h0: r = sw[7];
               2'h1: r = e.sio_tx_empty[2];
               2'h2: r = 1'b0;
               default: r = one[6];
            endcase
         4'h8:
            case (sel) // see R11
               2'h0: r = sw[8];
               2'h1: r = e.in_evt_bus[0];
               default: r = 1'b0;
            endcase
         default:
            case (sel) // see R12
               2'h0: r = sw[9];
               2'h3: r = one[8];
               default: r = 1'b0;
            endcase
      endcase
      return r;
   endfunction

   // lowest set bit wins, channel 0 first
   function automatic logic [3:0] first_set(input logic [tcd_pkg::NCH-1:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int k = tcd_pkg::NCH - 1; k >= 0; k--)
      begin
         if (v[k])
            r = 4'(k);
      end
      return r;
   endfunction

   // next address; ring mode keeps the upper bits and wraps the low ones
   function automatic logic [15:0] next_addr(input logic [15:0] a, input logic inc, input logic wide,
      input logic ring);
      logic [15:0] s;
      s = a + (wide ? 16'h0002 : 16'h0001);
      if (!inc)
         return a;
      if (ring && wide)
         return {a[15:6], s[5:0]};
      if (ring)
         return {a[15:5], s[4:0]}; // see R26
      return s;
   endfunction

   function automatic logic [31:0] bus_addr(input logic [15:0] a, input logic wide);
      // halfword units drop bit 0 so the access is always aligned
      return wide ? {tcd_pkg::WIN_HI, a[15:1], 1'b0} : {tcd_pkg::WIN_HI, a}; // see R20, R22
   endfunction

   function automatic logic [31:0] reg_read(input logic [11:0] a, input tcd_core_s s);
      logic [31:0] r;
      logic [3:0] c;
      r = 32'h0000_0000;
      c = a[8:5];
      if (a == tcd_pkg::OFF_STATUS)
         r = {22'h0, s.status};
      else if (a == tcd_pkg::OFF_MASK)
         r = {22'h0, s.mask};
      else if (a[11:9] == tcd_pkg::CH_REGION && c < 4'(tcd_pkg::NCH))
      begin
         if (a[4:0] == tcd_pkg::OFF_CTRL)
            r = {25'h0, s.ctrl[c]};
         else if (a[4:0] == tcd_pkg::OFF_SRC)
            r = {16'h0, s.src[c]};
         else if (a[4:0] == tcd_pkg::OFF_DST)
            r = {16'h0, s.dst[c]};
         else if (a[4:0] == tcd_pkg::OFF_CNT)
            r = {24'h0, s.cnt[c]};
      end
      return r;
   endfunction

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb
   begin
      logic [tcd_pkg::NCH-1:0] sw;
      logic [tcd_pkg::NCH-1:0] cause;
      logic [tcd_pkg::NCH-1:0] hw_set;
      logic [3:0] wc;
      logic [3:0] c;
      logic wide;
      logic ring;
      logic [7:0] byte_in;
      sw = '0;
      cause = '0;
      hw_set = '0;
      wc = s_q.waddr[8:5];
      c = s_q.cur;
      wide = 1'b0;
      ring = 1'b0;
      byte_in = 8'h00;
      s_d = s_q;
      s_d.one_done = '0;
      s_d.all_done = '0;
      s_d.hreadyout = 1'b1;

      // register writes, data phase of the previous address phase
      if (s_q.wr_ph)
      begin
         if (s_q.waddr == tcd_pkg::OFF_STATUS)
            s_d.status = s_q.status & hwdata[tcd_pkg::NCH-1:0]; // see R24
         else if (s_q.waddr == tcd_pkg::OFF_MASK)
            s_d.mask = hwdata[tcd_pkg::NCH-1:0];
         else if (s_q.waddr[11:9] == tcd_pkg::CH_REGION && wc < 4'(tcd_pkg::NCH))
         begin
            if (s_q.waddr[4:0] == tcd_pkg::OFF_CTRL)
               s_d.ctrl[wc] = hwdata[tcd_pkg::CTRL_W-1:0]; // see R2, R17
            else if (s_q.waddr[4:0] == tcd_pkg::OFF_SRC)
               s_d.src[wc] = hwdata[15:0];
            else if (s_q.waddr[4:0] == tcd_pkg::OFF_DST)
               s_d.dst[wc] = hwdata[15:0];
            else if (s_q.waddr[4:0] == tcd_pkg::OFF_CNT && !s_q.ctrl[wc][tcd_pkg::CTRL_EN])
               s_d.cnt[wc] = hwdata[7:0]; // locked while the channel is enabled
            else if (s_q.waddr[4:0] == tcd_pkg::OFF_SWREQ)
               sw[wc] = 1'b1; // see R13
         end
      end

      // transfer engine
      case (s_q.st)
         tcd_pkg::ST_IDLE:
         begin
            if (s_q.pend != '0)
            begin
               // losers keep their pending bit for the next cycle
               s_d.cur = first_set(s_q.pend); // see R15, R27
               s_d.pend[first_set(s_q.pend)] = 1'b0;
               s_d.bus_req = 1'b1; // see R16
               s_d.st = tcd_pkg::ST_GRANT;
            end
         end
         tcd_pkg::ST_GRANT:
         begin
            if (bus_gnt)
            begin
               wide = s_q.ctrl[c][tcd_pkg::CTRL_SIZE];
               s_d.mem.addr = bus_addr(s_q.src[c], wide);
               s_d.mem.be = wide ? 2'h3 : (s_q.src[c][0] ? 2'h1 : 2'h2);
               s_d.mem.rd = 1'b1;
               s_d.st = tcd_pkg::ST_READ;
            end
         end
         tcd_pkg::ST_READ:
         begin
            if (mem_ready)
            begin
               wide = s_q.ctrl[c][tcd_pkg::CTRL_SIZE];
               // even byte rides the upper lane
               byte_in = s_q.src[c][0] ? mem_rdata[7:0] : mem_rdata[15:8];
               s_d.hold = mem_rdata;
               s_d.hold_byte = byte_in;
               s_d.mem.rd = 1'b0;
               s_d.mem.wr = 1'b1; // see R16
               s_d.mem.addr = bus_addr(s_q.dst[c], wide);
               s_d.mem.be = wide ? 2'h3 : (s_q.dst[c][0] ? 2'h1 : 2'h2); // see R22
               s_d.mem.wdata = wide ? mem_rdata : {byte_in, byte_in};
               s_d.st = tcd_pkg::ST_WRITE;
            end
         end
         default:
         begin
            if (mem_ready)
            begin
               wide = s_q.ctrl[c][tcd_pkg::CTRL_SIZE];
               ring = s_q.ctrl[c][tcd_pkg::CTRL_RING];
               s_d.mem.wr = 1'b0;
               s_d.bus_req = 1'b0; // see R16
               s_d.src[c] = next_addr(s_q.src[c], s_q.ctrl[c][tcd_pkg::CTRL_SINC], wide, ring); // see R21, R23
               s_d.dst[c] = next_addr(s_q.dst[c], s_q.ctrl[c][tcd_pkg::CTRL_DINC], wide, ring); // see R21, R23
               s_d.cnt[c] = s_q.cnt[c] - 8'h01; // see R18, R19
               s_d.one_done[c] = 1'b1;
               if (!ring && s_q.cnt[c] == tcd_pkg::CNT_LAST)
               begin
                  s_d.ctrl[c][tcd_pkg::CTRL_EN] = 1'b0; // see R25
                  s_d.all_done[c] = 1'b1;
                  hw_set[c] = 1'b1;
               end
               s_d.st = tcd_pkg::ST_IDLE;
            end
         end
      endcase

      // hardware set beats a software clear in the same cycle
      s_d.status = s_d.status | hw_set; // see R1, R24
      s_d.irq = s_d.status & ~s_d.mask; // see R1

      // request capture per channel
      for (int i = 0; i < tcd_pkg::NCH; i++)
      begin
         cause[i] = cause_of(4'(i), s_q.ctrl[i][tcd_pkg::CTRL_SEL +: 2], evt, sw, s_q.one_done, s_q.all_done);
         if (!s_d.ctrl[i][tcd_pkg::CTRL_EN])
            s_d.pend[i] = 1'b0; // see R14
         else if (cause[i] && s_q.ctrl[i][tcd_pkg::CTRL_EN])
            s_d.pend[i] = 1'b1; // see R14
      end

      // ahb address phase; reads see this cycle's writes
      s_d.wr_ph = 1'b0;
      s_d.hrdata = 32'h0000_0000;
      if (hsel && htrans[1] && hready)
      begin
         if (hwrite)
         begin
            s_d.wr_ph = 1'b1;
            s_d.waddr = haddr[11:0];
         end
         else
            s_d.hrdata = reg_read(haddr[11:0], s_d);
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s_q <= '0;
         s_q.st <= tcd_pkg::ST_IDLE;
         s_q.cnt <= {tcd_pkg::NCH{tcd_pkg::CNT_RST}};
      end
      else
         s_q <= s_d;
   end

   assign hrdata = s_q.hrdata;
   assign hreadyout = s_q.hreadyout;
   assign hresp = 1'b0;
   assign bus_req = s_q.bus_req;
   assign mem = s_q.mem;
   assign irq = s_q.irq;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   logic [tcd_pkg::NCH-1:0] en_vec;
   logic [7:0] cur_cnt;
   logic [15:0] cur_src;
   logic [10:0] cur_src_hi;
   logic cur_en;
   logic cur_ring;
   logic cur_wide;
   logic cur_sinc;
   always_comb
   begin
      for (int i = 0; i < tcd_pkg::NCH; i++)
         en_vec[i] = s_q.ctrl[i][tcd_pkg::CTRL_EN];
   end
   assign cur_cnt = s_q.cnt[s_q.cur];
   assign cur_src = s_q.src[s_q.cur];
   assign cur_src_hi = cur_src[15:5];
   assign cur_en = s_q.ctrl[s_q.cur][tcd_pkg::CTRL_EN];
   assign cur_ring = s_q.ctrl[s_q.cur][tcd_pkg::CTRL_RING];
   assign cur_wide = s_q.ctrl[s_q.cur][tcd_pkg::CTRL_SIZE];
   assign cur_sinc = s_q.ctrl[s_q.cur][tcd_pkg::CTRL_SINC];

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_read_done;
      s_q.mem.rd && mem_ready;
   endsequence
   sequence s_write_done;
      s_q.mem.wr && mem_ready;
   endsequence

   a_mask_blocks_irq: assert property ((irq & s_q.mask) == '0) // see R1
      else $error("masked channel drove its interrupt");
   a_status_on_end: assert property (s_write_done and (cur_cnt == 8'h00 && !cur_ring) |=> s_q.status[s_q.cur]) // see R1
      else $error("status not set at end of transfers");
   a_no_pend_off: assert property ((s_q.pend & ~en_vec) == '0) // see R14
      else $error("disabled channel holds a request");
   a_fixed_priority: assert property ((s_q.st == tcd_pkg::ST_IDLE && s_q.pend != '0) |=> // see R15
      (s_q.st == tcd_pkg::ST_GRANT && s_q.cur == first_set($past(s_q.pend))))
      else $error("wrong channel won arbitration");
   a_read_then_write: assert property (s_read_done |=> s_q.mem.wr && !s_q.mem.rd) // see R16
      else $error("write did not follow read");
   a_bus_release: assert property (s_write_done |=> !bus_req && !s_q.mem.wr ##1 s_q.st != tcd_pkg::ST_READ) // see R16
      else $error("bus not returned after one transfer");
   a_count_step: assert property (s_write_done |=> cur_cnt == 8'($past(cur_cnt) - 8'h01)) // see R18
      else $error("count did not drop by one");
   a_stop_underflow: assert property (s_write_done and (cur_cnt == 8'h00 && !cur_ring) |=> !cur_en) // see R25
      else $error("channel kept running after underflow");
   a_ring_wrap: assert property (s_write_done and (cur_ring && cur_sinc && !cur_wide && cur_src[4:0] == 5'h1F) // see R23
      |=> cur_src[4:0] == 5'h00 && cur_src_hi == $past(cur_src_hi))
      else $error("ring address did not wrap to start");

endmodule

`default_nettype wire

/* File: tcd_pkg.sv */
// ten-channel dma controller: shared constants, types and a summary of behaviour
// How it works
// R1 - status bit sets on every completion; the mask only blocks the interrupt output
// R2 - each channel picks its request cause with a two-bit field at control bits 2 and 3
// R3 - ch0 causes: software or ch2 one-done, converter 0, timer ch8 underflow, input bus 2
// R4 - ch1 causes: software, output bus 0, none, ch0 one-done
// R5 - ch2 causes: software, output bus 1, timer input 18, ch1 one-done
// R6 - ch3 causes: software, serial 0 tx empty, serial 1 rx done, timer input 0
// R7 - ch4 causes: software, ch3 one-done, serial 0 rx done, timer input 19
// R8 - ch5 causes: software or ch7 one-done, ch0 all-done, serial 2 rx done, timer input 20
// R9 - ch6 causes: software, serial 1 tx empty, none, ch5 one-done
// R10 - ch7 causes: software, serial 2 tx empty, none, ch6 one-done
// R11 - ch8 causes: software, input bus 0, none, none
// R12 - ch9 causes: software, none, none, ch8 one-done
// R13 - any write to a channel's software request register raises its software start
// R14 - a channel starts only on a cause seen while its enable bit is 1
// R15 - lowest pending channel wins; arbitration repeats every transfer cycle
// R16 - one transfer per grant: source read into holding register, destination write, release bus
// R17 - per-channel size bit selects 8-bit or 16-bit units
// R18 - normal mode counts down once per unit, up to 256 transfers
// R19 - ring mode count runs free and never stops the channel
// R20 - all addresses lie inside the 64-Kbyte window at 0080_0000
// R21 - fixed addresses stay; incrementing ones step by 1 or 2 per unit
// R22 - byte units use address bit 0 as lane; halfword units ignore it
// R23 - ring mode wraps the incrementing address back to the start after 32 transfers
// R24 - status bits set only by hardware; writing 0 clears, writing 1 keeps
// R25 - normal mode stops on underflow, clears enable, raises completion; ring never does
// R26 - ring mode with byte units only moves the five low address bits
// R27 - a request that loses arbitration stays pending for a later cycle
package tcd_pkg;

   localparam int NCH = 10;

   // register map, byte offsets inside the block's 4-Kbyte slot
   localparam logic [11:0] OFF_STATUS = 12'h000;
   localparam logic [11:0] OFF_MASK = 12'h004;
   localparam logic [2:0] CH_REGION = 3'h2;
   localparam logic [4:0] OFF_CTRL = 5'h00;
   localparam logic [4:0] OFF_SRC = 5'h04;
   localparam logic [4:0] OFF_DST = 5'h08;
   localparam logic [4:0] OFF_CNT = 5'h0C;
   localparam logic [4:0] OFF_SWREQ = 5'h10;

   // control register fields
   localparam int CTRL_W = 7;
   localparam int CTRL_EN = 0;
   localparam int CTRL_RING = 1;
   localparam int CTRL_SEL = 2;
   localparam int CTRL_SIZE = 4;
   localparam int CTRL_SINC = 5;
   localparam int CTRL_DINC = 6;

   localparam logic [15:0] WIN_HI = 16'h0080;
   localparam logic [7:0] CNT_RST = 8'h00;
   localparam logic [7:0] CNT_LAST = 8'h00;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_GRANT = 2'b01,
      ST_READ = 2'b10,
      ST_WRITE = 2'b11
   } tcd_state_e;

   // peripheral request pulses, all on hclk
   typedef struct packed {
      logic converter_0_done;
      logic timer_ch8_underflow;
      logic timer_input_0;
      logic timer_input_18;
      logic timer_input_19;
      logic timer_input_20;
      logic [2:0] in_evt_bus;
      logic [1:0] out_evt_bus;
      logic [2:0] sio_tx_empty;
      logic [2:0] sio_rx_done;
   } tcd_evt_s;

   // internal bus master side
   typedef struct packed {
      logic [31:0] addr;
      logic [1:0] be;
      logic [15:0] wdata;
      logic rd;
      logic wr;
   } tcd_mem_s;

endpackage

/* File: tcd_ram.sv */
// memory and bus owner model on the dma controller's internal bus
`timescale 1ns/1ps
`default_nettype none
module tcd_ram
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic slow,
   input wire logic bus_req,
   output logic bus_gnt,
   input wire tcd_pkg::tcd_mem_s mem,
   output logic [15:0] mem_rdata,
   output logic mem_ready
);
   logic [15:0] ram [0:32767];
   logic [1:0] wait_q;
   logic [15:0] last_q;
   logic act;
   assign act = (mem.rd || mem.wr) && !mem_ready;
   // released data lines show the inverse, so a stale value never reads as good
   assign mem_rdata = (mem.rd && mem_ready) ? ram[mem.addr[15:1]] : ~last_q;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         bus_gnt <= 1'b0;
         mem_ready <= 1'b0;
         wait_q <= 2'h0;
         last_q <= 16'h0;
      end
      else
      begin
         // grant follows the request and drops as the write completes
         bus_gnt <= bus_req && !(mem.wr && mem_ready);
         mem_ready <= act && wait_q == (slow ? 2'h2 : 2'h0);
         wait_q <= (act && wait_q != (slow ? 2'h2 : 2'h0)) ? wait_q + 2'h1 : 2'h0;
         if (mem.rd && mem_ready)
            last_q <= ram[mem.addr[15:1]];
      end
   end
   // plain process so the bench may preload and inspect the array
   always @(posedge hclk)
   begin
      if (mem.wr && mem_ready && mem.be[1])
         ram[mem.addr[15:1]][15:8] <= mem.wdata[15:8];
      if (mem.wr && mem_ready && mem.be[0])
         ram[mem.addr[15:1]][7:0] <= mem.wdata[7:0];
   end
endmodule
`default_nettype wire

/* File: ten_channel_dma_controller_bench.sv */
// self-checking bench for the ten-channel dma controller
`timescale 1ns/1ps
`default_nettype none
module ten_channel_dma_controller_bench;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic slow = 1'b0;
   tcd_pkg::tcd_evt_s evt = '0;
   logic bus_req;
   logic bus_gnt;
   tcd_pkg::tcd_mem_s mem;
   logic [15:0] mem_rdata;
   logic mem_ready;
   logic [9:0] irq;
   int error_cnt = 0;
   int total_checks = 0;
   logic [31:0] rv;
   localparam logic [4:0] cn = tcd_pkg::OFF_CNT;
   localparam logic [4:0] ct = tcd_pkg::OFF_CTRL;
   localparam logic [11:0] st = tcd_pkg::OFF_STATUS;
   localparam logic [11:0] mk = tcd_pkg::OFF_MASK;
   always #5 hclk = ~hclk;
   tcd_dma tcd_dma_inst (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .evt(evt), .bus_req(bus_req), .bus_gnt(bus_gnt), .mem(mem),
      .mem_rdata(mem_rdata), .mem_ready(mem_ready), .irq(irq));
   tcd_ram tcd_ram_inst (.hclk(hclk), .hresetn(hresetn), .slow(slow), .bus_req(bus_req),
      .bus_gnt(bus_gnt), .mem(mem), .mem_rdata(mem_rdata), .mem_ready(mem_ready));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic hang(input logic ok);
      if (!ok)
      begin
         chk("wait limit", 0, 1);
         wrap_up();
      end
   endtask
   task automatic wait_rdy;
      int n;
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 50);
      hang(hreadyout === 1'b1);
   endtask
   // the address phase holds until hready, then data phase until hready again
   task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      htrans <= 2'h2;
      haddr <= {20'h0, a};
      hwrite <= wr;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rv = hrdata;
   endtask
   task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0);
      chk(nm, rv, exp);
      chk("okay", 32'(hresp), 32'h0);
   endtask
   function automatic logic [11:0] ca(input int n, input logic [4:0] o);
      return 12'h400 + 12'(n * 32) + 12'(o);
   endfunction
   task automatic setch(input int n, input logic [6:0] c, input logic [15:0] s, input logic [15:0] d,
      input logic [7:0] k);
      ahb(1'b1, ca(n, tcd_pkg::OFF_SRC), 32'(s));
      ahb(1'b1, ca(n, tcd_pkg::OFF_DST), 32'(d));
      ahb(1'b1, ca(n, cn), 32'(k));
      ahb(1'b1, ca(n, ct), 32'(c));
   endtask
   task automatic sw(input int n);
      ahb(1'b1, ca(n, tcd_pkg::OFF_SWREQ), 32'h0);
   endtask
   // quiet means no bus request for eight cycles, which also covers cascades
   task automatic settle;
      int n;
      int q;
      q = 0;
      for (n = 0; n < 300 && q < 8; n++)
      begin
         @(posedge hclk);
         q = (bus_req === 1'b0) ? q + 1 : 0;
      end
      hang(q == 8);
   endtask
   task automatic pulse(input logic [16:0] b);
      evt <= b;
      @(posedge hclk);
      evt <= '0;
   endtask
   always @(posedge hclk)
   begin
      if (mem.rd === 1'b1 || mem.wr === 1'b1)
      begin
         chk("window", 32'(mem.addr[31:16]), 32'(tcd_pkg::WIN_HI));
         chk("rd and wr", 32'(mem.rd & mem.wr), 32'h0);
      end
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs;
      rchk("status", st, 32'h0);
      rchk("mask", mk, 32'h0);
      rchk("count", ca(4, cn), 32'h0);
      rchk("unmapped", 12'hFFC, 32'h0);
      ahb(1'b1, st, 32'h3FF);
      rchk("sw set", st, 32'h0);
      $display("test regs done");
   endtask
   task automatic t_norm;
      tcd_ram_inst.ram[8] = 16'hAABB;
      tcd_ram_inst.ram[9] = 16'hCCDD;
      tcd_ram_inst.ram[128] = 16'h0;
      tcd_ram_inst.ram[129] = 16'h0;
      setch(0, 7'h60, 16'h0011, 16'h0100, 8'h02);
      sw(0);
      settle();
      rchk("no start", ca(0, cn), 32'h2);
      ahb(1'b1, ca(0, ct), 32'h61);
      ahb(1'b1, ca(0, cn), 32'h9);
      for (int i = 0; i < 3; i++)
      begin
         rchk("early status", st, 32'h0);
         sw(0);
         settle();
      end
      chk("lanes", 32'(tcd_ram_inst.ram[128]), 32'hBBCC);
      chk("third", 32'(tcd_ram_inst.ram[129][15:8]), 32'hDD);
      rchk("src", ca(0, tcd_pkg::OFF_SRC), 32'h14);
      rchk("dst", ca(0, tcd_pkg::OFF_DST), 32'h103);
      rchk("underflow", ca(0, cn), 32'hFF);
      rchk("enable off", ca(0, ct), 32'h60);
      rchk("done status", st, 32'h1);
      chk("irq", 32'(irq), 32'h1);
      ahb(1'b1, mk, 32'h1);
      ahb(1'b1, st, 32'h3FF);
      rchk("kept", st, 32'h1);
      chk("masked", 32'(irq), 32'h0);
      ahb(1'b1, st, 32'h0);
      ahb(1'b1, mk, 32'h0);
      rchk("cleared", st, 32'h0);
      $display("test normal done");
   endtask
   task automatic t_half;
      slow <= 1'b1;
      ahb(1'b1, mk, 32'h8);
      tcd_ram_inst.ram[16] = 16'h1234;
      tcd_ram_inst.ram[17] = 16'h5678;
      tcd_ram_inst.ram[256] = 16'h0;
      setch(3, 7'h31, 16'h0020, 16'h0201, 8'h01);
      repeat (2)
      begin
         sw(3);
         settle();
      end
      chk("halfword", 32'(tcd_ram_inst.ram[256]), 32'h5678);
      rchk("src", ca(3, tcd_pkg::OFF_SRC), 32'h24);
      rchk("dst fixed", ca(3, tcd_pkg::OFF_DST), 32'h201);
      rchk("status", st, 32'h8);
      chk("irq", 32'(irq), 32'h0);
      ahb(1'b1, st, 32'h0);
      ahb(1'b1, mk, 32'h0);
      slow <= 1'b0;
      $display("test half done");
   endtask
   task automatic t_ring;
      setch(2, 7'h23, 16'h1FE0, 16'h0300, 8'h00);
      repeat (32)
      begin
         sw(2);
         settle();
      end
      rchk("wrap", ca(2, tcd_pkg::OFF_SRC), 32'h1FE0);
      rchk("still on", ca(2, ct), 32'h23);
      rchk("no status", st, 32'h0);
      sw(2);
      settle();
      rchk("step", ca(2, tcd_pkg::OFF_SRC), 32'h1FE1);
      ahb(1'b1, ca(2, ct), 32'h22);
      $display("test ring done");
   endtask
   task automatic t_prio;
      int n;
      setch(3, 7'h05, 16'h0500, 16'h0700, 8'h05);
      setch(6, 7'h05, 16'h0600, 16'h0702, 8'h05);
      @(posedge hclk);
      pulse(17'h00018);
      for (n = 0; n < 50 && mem.rd !== 1'b1; n++)
         @(posedge hclk);
      hang(mem.rd === 1'b1);
      chk("winner", 32'(mem.addr[15:0]), 32'h500);
      settle();
      rchk("loser", ca(6, cn), 32'h4);
      ahb(1'b1, ca(3, ct), 32'h0);
      ahb(1'b1, ca(6, ct), 32'h0);
      $display("test priority done");
   endtask
   task automatic t_causes;
      int t [16] = '{'h0110, 'h020F, 'h030A, 'h1106, 'h2107, 'h220D, 'h3103, 'h3201, 'h330E, 'h4200,
         'h430C, 'h5202, 'h530B, 'h6104, 'h7105, 'h8108};
      int c;
      foreach (t[i])
      begin
         c = t[i] >> 12;
         setch(c, 7'(1 + ((t[i] >> 6) & 12)), 16'h0800, 16'h0802, 8'h05);
         @(posedge hclk);
         pulse(17'(1) << (t[i] & 255));
         settle();
         rchk("cause", ca(c, cn), 32'h4);
         ahb(1'b1, ca(c, ct), 32'h0);
      end
      setch(1, 7'h09, 16'h0800, 16'h0802, 8'h05);
      @(posedge hclk);
      pulse(17'h1FFFF);
      settle();
      rchk("prohibited", ca(1, cn), 32'h5);
      ahb(1'b1, ca(1, ct), 32'h0);
      $display("test causes done");
   endtask
   task automatic t_cascade;
      for (int i = 1; i < 10; i++)
         if (i inside {1, 2, 6, 7, 9})
            setch(i, 7'h0D, 16'h0800, 16'h0802, 8'h05);
      setch(5, 7'h05, 16'h0800, 16'h0802, 8'h05);
      setch(8, 7'h01, 16'h0800, 16'h0802, 8'h05);
      setch(0, 7'h01, 16'h0800, 16'h0804, 8'h00);
      sw(0);
      sw(8);
      settle();
      rchk("one done", ca(1, cn), 32'h4);
      rchk("all done", ca(5, cn), 32'h4);
      rchk("ch8 start", ca(8, cn), 32'h4);
      rchk("ch8 chain", ca(9, cn), 32'h4);
      for (int i = 2; i < 8; i++)
         if (i inside {2, 6, 7})
            rchk("chain", ca(i, cn), 32'h4);
      for (int i = 0; i < 10; i++)
         ahb(1'b1, ca(i, ct), 32'h0);
      ahb(1'b1, st, 32'h0);
      $display("test cascade done");
   endtask
   initial
   begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs();
      t_norm();
      t_half();
      t_ring();
      t_prio();
      t_causes();
      t_cascade();
      wrap_up();
   end
endmodule
`default_nettype wire
